// >>> shared/wpm_cfg.svh
`ifndef WPM_CFG_SVH
`define WPM_CFG_SVH
// register byte addresses
`define WPM_PWR_CTRL_ADDR   12'h084
`define WPM_IRQ_STS_ADDR    12'h058
`define WPM_IRQ_EN_ADDR     12'h05c
`define WPM_HARDWARE_CONFIG_REGISTER_ADDR     12'h074
`define WPM_WAKE_CFG_ADDR   12'h0a0
`define WPM_ADDR_W          12
// power control field positions
`define WPM_MODE_HI         31
`define WPM_MODE_LO         29
`define WPM_SLEEP_BIT       28
`define WPM_AUTO_WAKE_BIT   27
`define WPM_LED_OUTPUTS_DISABLE_BIT     26
`define WPM_TSYNC_DIS_BIT   25
`define WPM_TSU_DIS_BIT     22
`define WPM_MAC_DIS_BIT     19
`define WPM_MAC_SYS_DIS_BIT 18
`define WPM_ENERGY_DETECT_ENABLE_BIT       14
`define WPM_MACW_EN_BIT     9
`define WPM_ENERGY_DETECT_STATUS_BIT      16
`define WPM_MACW_STS_BIT    5
`define WPM_READY_BIT       0
// wake configuration field positions
`define WPM_PIN_EN_BIT      1
`define WPM_PIN_POL_BIT     2
`define WPM_PIN_PULSE_BIT   3
`define WPM_PIN_OD_BIT      6
// irq status / enable positions
`define WPM_PE_IRQ_BIT      17
`define WPM_OTHER_IRQ_BIT   0
// hardware config ready bit
`define WPM_HW_READY_BIT    27
// mode codes
`define WPM_MODE_D0         3'h0
`define WPM_MODE_D1         3'h1
`define WPM_MODE_D2         3'h2
`define WPM_MODE_D3         3'h3
// reset values
`define WPM_PWR_CTRL_RST    32'h0000_0000
`define WPM_WAKE_CFG_RST    8'h00
// timing
`define WPM_CLK_HZ          25000000
`define WPM_PULSE_US        50000
`define WPM_PULSE_CYC       ((`WPM_PULSE_US * (`WPM_CLK_HZ / 1000000)))
`define WPM_WAKE_MAX_US     2000
`define WPM_WAKE_MAX_CYC    ((`WPM_WAKE_MAX_US * (`WPM_CLK_HZ / 1000000)))
`define WPM_PLL_LOCK_CYC    64
`endif

// >>> shared/wpm_pkg.sv
package wpm_pkg;
  typedef enum logic [1:0] {
    WPM_HTRANS_IDLE   = 2'h0,
    WPM_HTRANS_BUSY   = 2'h1,
    WPM_HTRANS_NONSEQ = 2'h2,
    WPM_HTRANS_SEQ    = 2'h3
  } wpm_htrans_t;

  // ahb-lite request from the master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    wpm_htrans_t htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } wpm_ahb_req_t;

  // gated clock enables toward the blocks
  typedef struct packed {
    logic sys_clk_en;
    logic mac_sys_clk_en;
    logic mac_net_clk_en;
    logic tsync_clk_en;
    logic tsu_clk_en;
    logic pll_en;
    logic xtal_en;
    logic net_clk_en;
  } wpm_clk_ctrl_t;
endpackage : wpm_pkg

// >>> rtl/wpm_core.sv
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`include "wpm_cfg.svh"
module wpm_core #(
  parameter int PULSE_CYC    = `WPM_PULSE_CYC,
  parameter int PLL_LOCK_CYC = `WPM_PLL_LOCK_CYC,
  parameter int LED_N        = 3
) (
  input  wire logic                  CLOCK_I,
  input  wire logic                  RST_I,
  input  wire wpm_pkg::wpm_ahb_req_t AHB_I,
  output logic [31:0]                HRDATA_O,
  output logic                       HREADYOUT_O,
  output logic                       HRESP_O,
  input  wire logic                  MAC_WAKE_I,
  input  wire logic                  ENERGY_ON_I,
  input  wire logic                  OTHER_IRQ_I,
  input  wire logic                  PHY_DOWN_I,
  input  wire logic                  HOST_WAKE_I,
  input  wire logic [LED_N-1:0]      LED_I,
  input  wire logic [LED_N-1:0]      LED_OD_I,
  input  wire logic [LED_N-1:0]      LED_POL_I,
  output logic [LED_N-1:0]           LED_O,
  output logic [LED_N-1:0]           LED_OE_O,
  output logic                       IRQ_O,
  output logic                       WAKE_PIN_O,
  output logic                       WAKE_PIN_OE_O,
  output wpm_pkg::wpm_clk_ctrl_t     CLK_CTRL_O,
  output logic                       READY_O,
  output logic                       SLEEPING_O
);
  import wpm_pkg::*;

  typedef enum logic [2:0] {
    PS_D0, PS_D1, PS_D2, PS_D3, PS_LOCK
  } wpm_pstate_t;

  localparam int PCW = $clog2(PULSE_CYC + 1);
  localparam int LKW = $clog2(PLL_LOCK_CYC + 1);

  // mac wake, energy, host wake and phy down pins pass two flops before use
  logic [1:0] macw_sync_r, ed_sync_r, hwake_sync_r, phyd_sync_r;
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      macw_sync_r  <= 2'h0;
      ed_sync_r    <= 2'h0;
      hwake_sync_r <= 2'h0;
      phyd_sync_r  <= 2'h0;
    end else begin
      macw_sync_r  <= {macw_sync_r[0], MAC_WAKE_I};
      ed_sync_r    <= {ed_sync_r[0], ENERGY_ON_I};
      hwake_sync_r <= {hwake_sync_r[0], HOST_WAKE_I};
      phyd_sync_r  <= {phyd_sync_r[0], PHY_DOWN_I};
    end
  end

  // registered address phase
  logic        dp_wr_r, dp_rd_r;
  logic [11:0] dp_addr_r;
  logic        req_ok;
  assign req_ok = AHB_I.hsel && AHB_I.hready && AHB_I.htrans[1];

  // write decode in the data phase
  function automatic logic wr_hit(input logic [11:0] a);
    return dp_wr_r && (dp_addr_r == a);
  endfunction : wr_hit

  // configuration and state registers
  logic [2:0]  mode_r;
  logic        sleep_r, auto_wake_r, led_outputs_disable_r;
  logic        macw_en_r, energy_detect_enable_r, macw_sts_r, energy_detect_status_r;
  logic        pe_irq_r, pe_irq_en_r, other_en_r;
  logic [7:0]  wcfg_r;
  logic [3:0]  dis_r, dis_cnt_r;
  wpm_pstate_t ps_r;
  logic [LKW-1:0] lock_cnt_r;
  logic [31:0] wd;
  assign wd = AHB_I.hwdata;

  // protected disable bits in order: mac, mac sys, sync, tsu
  logic [3:0] dis_wbit;
  assign dis_wbit = {wd[`WPM_TSU_DIS_BIT], wd[`WPM_TSYNC_DIS_BIT],
                     wd[`WPM_MAC_SYS_DIS_BIT], wd[`WPM_MAC_DIS_BIT]};

  logic host_ok;
  assign host_ok = (ps_r == PS_D0);

  // two-write lock per bit; zero write clears count and bit
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      dis_r     <= 4'h0;
      dis_cnt_r <= 4'h0;
    end else if (host_ok && wr_hit(`WPM_PWR_CTRL_ADDR)) begin
      for (int i = 0; i < 4; i++) begin
        if (!dis_wbit[i]) begin
          dis_cnt_r[i] <= 1'b0;
          dis_r[i]     <= 1'b0;
        end else if (dis_cnt_r[i] || dis_r[i]) begin
          dis_r[i]     <= 1'b1;
        end else begin
          dis_cnt_r[i] <= 1'b1;
        end
      end
    end
  end

  // plain control bits; held across every power state
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      auto_wake_r <= 1'b0;
      led_outputs_disable_r   <= 1'b0;
      macw_en_r   <= 1'b0;
      energy_detect_enable_r     <= 1'b0;
      wcfg_r      <= `WPM_WAKE_CFG_RST;
      pe_irq_en_r <= 1'b0;
      other_en_r  <= 1'b0;
    end else if (host_ok) begin
      if (wr_hit(`WPM_PWR_CTRL_ADDR)) begin
        auto_wake_r <= wd[`WPM_AUTO_WAKE_BIT];
        led_outputs_disable_r   <= wd[`WPM_LED_OUTPUTS_DISABLE_BIT];
        macw_en_r   <= wd[`WPM_MACW_EN_BIT];
        energy_detect_enable_r     <= wd[`WPM_ENERGY_DETECT_ENABLE_BIT];
      end
      if (wr_hit(`WPM_WAKE_CFG_ADDR)) begin
        wcfg_r <= wd[7:0];
      end
      if (wr_hit(`WPM_IRQ_EN_ADDR)) begin
        pe_irq_en_r <= wd[`WPM_PE_IRQ_BIT];
        other_en_r  <= wd[`WPM_OTHER_IRQ_BIT];
      end
    end
  end

  // sticky wake statuses, write one to clear, set wins
  logic macw_clr, ed_clr;
  always_comb macw_clr = host_ok && wr_hit(`WPM_PWR_CTRL_ADDR) && wd[`WPM_MACW_STS_BIT]; // comb sees decode flops
  always_comb ed_clr   = host_ok && wr_hit(`WPM_PWR_CTRL_ADDR) && wd[`WPM_ENERGY_DETECT_STATUS_BIT];
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      macw_sts_r <= 1'b0;
      energy_detect_status_r   <= 1'b0;
    end else begin
      macw_sts_r <= macw_sync_r[1] | (macw_sts_r & ~macw_clr);
      energy_detect_status_r   <= ed_sync_r[1] | (energy_detect_status_r & ~ed_clr);
    end
  end

  // power event and its interrupt status
  logic pe_evt, pe_clr;
  assign pe_evt = (macw_sts_r & macw_en_r) | (energy_detect_status_r & energy_detect_enable_r);
  always_comb pe_clr = host_ok && wr_hit(`WPM_IRQ_STS_ADDR) && wd[`WPM_PE_IRQ_BIT];
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pe_irq_r <= 1'b0;
    end else begin
      pe_irq_r <= pe_evt | (pe_irq_r & ~pe_clr);
    end
  end

  // interrupt pin: only the enabled status reaches it
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= (pe_irq_r & pe_irq_en_r) | (OTHER_IRQ_I & other_en_r);
    end
  end

  // mode and sleep writes; same-write conflicts drop mode and sleep
  logic mode_wr, sleep_wr, wake_done;
  always_comb mode_wr  = host_ok && wr_hit(`WPM_PWR_CTRL_ADDR) && !wd[`WPM_SLEEP_BIT];
  always_comb sleep_wr = host_ok && wr_hit(`WPM_PWR_CTRL_ADDR) && wd[`WPM_SLEEP_BIT]
                         && (wd[`WPM_MODE_HI:`WPM_MODE_LO] == mode_r);
  assign wake_done = (ps_r == PS_LOCK) && (lock_cnt_r == LKW'(PLL_LOCK_CYC));
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mode_r  <= `WPM_MODE_D0;
      sleep_r <= 1'b0;
    end else if (wake_done) begin
      mode_r  <= `WPM_MODE_D0;
      sleep_r <= 1'b0;
    end else if (mode_wr) begin
      mode_r  <= wd[`WPM_MODE_HI:`WPM_MODE_LO];
    end else if (sleep_wr) begin
      sleep_r <= 1'b1;
    end
  end

  // power state sequencer; reserved codes stay in D0
  logic auto_ok;
  assign auto_ok = auto_wake_r && pe_evt;
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ps_r       <= PS_D0;
      lock_cnt_r <= '0;
    end else begin
      case (ps_r)
        PS_D0: begin
          lock_cnt_r <= '0;
          if (sleep_wr) begin
            case (mode_r)
              `WPM_MODE_D1: ps_r <= PS_D1;
              `WPM_MODE_D2: ps_r <= PS_D2;
              `WPM_MODE_D3: ps_r <= PS_D3;
              default:      ps_r <= PS_D0;
            endcase
          end
        end
        PS_D1, PS_D2: begin
          if (hwake_sync_r[1] || auto_ok) ps_r <= PS_LOCK;
        end
        PS_D3: begin
          if (hwake_sync_r[1]) ps_r <= PS_LOCK;
        end
        PS_LOCK: begin
          // pll settle, far below the wake bound
          if (wake_done) ps_r <= PS_D0;
          else lock_cnt_r <= lock_cnt_r + LKW'(1);
        end
        default: ps_r <= PS_D0;
      endcase
    end
  end

  // clock gating; blocks are frozen, never reset
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      CLK_CTRL_O <= '{default: 1'b1};
    end else begin
      CLK_CTRL_O.sys_clk_en     <= (ps_r == PS_D0);
      CLK_CTRL_O.mac_sys_clk_en <= (ps_r == PS_D0) && !dis_r[0] && !dis_r[1];
      CLK_CTRL_O.mac_net_clk_en <= (ps_r != PS_D3) && !dis_r[0];
      CLK_CTRL_O.tsync_clk_en   <= (ps_r == PS_D0) && !dis_r[2];
      CLK_CTRL_O.tsu_clk_en     <= (ps_r == PS_D0) && !dis_r[2] && !dis_r[3];
      CLK_CTRL_O.pll_en         <= !((ps_r == PS_D2) && phyd_sync_r[1]) && (ps_r != PS_D3);
      CLK_CTRL_O.xtal_en        <= (ps_r != PS_D3);
      CLK_CTRL_O.net_clk_en     <= (ps_r != PS_D3);
    end
  end

  // wake pin: pulse counter and drive
  logic [PCW-1:0] pulse_cnt_r;
  logic           pe_evt_d_r, pin_act;
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pe_evt_d_r  <= 1'b0;
      pulse_cnt_r <= '0;
    end else begin
      pe_evt_d_r <= pe_evt;
      if (pe_evt && !pe_evt_d_r) pulse_cnt_r <= PCW'(PULSE_CYC);
      else if (pulse_cnt_r != '0) pulse_cnt_r <= pulse_cnt_r - PCW'(1);
    end
  end
  assign pin_act = wcfg_r[`WPM_PIN_EN_BIT] &&
                   (wcfg_r[`WPM_PIN_PULSE_BIT] ? (pulse_cnt_r != '0) : pe_evt);
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      WAKE_PIN_O    <= 1'b0;
      WAKE_PIN_OE_O <= 1'b0;
    end else if (wcfg_r[`WPM_PIN_OD_BIT]) begin
      WAKE_PIN_O    <= 1'b0; // open drain pulls low
      WAKE_PIN_OE_O <= pin_act;
    end else begin
      WAKE_PIN_O    <= pin_act ^ ~wcfg_r[`WPM_PIN_POL_BIT];
      WAKE_PIN_OE_O <= 1'b1;
    end
  end

  // led pins: open drain released, push-pull parked inactive
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      LED_O    <= '0;
      LED_OE_O <= '0;
    end else begin
      for (int i = 0; i < LED_N; i++) begin
        if (led_outputs_disable_r) begin
          LED_O[i]    <= ~LED_POL_I[i];
          LED_OE_O[i] <= ~LED_OD_I[i];
        end else begin
          LED_O[i]    <= LED_I[i];
          LED_OE_O[i] <= 1'b1;
        end
      end
    end
  end

  // ahb slave: zero wait, okay, registered read data
  logic [31:0] rd_nxt, pc_word;
  always_comb begin
    pc_word = 32'h0;
    pc_word[`WPM_MODE_HI:`WPM_MODE_LO] = mode_r;
    pc_word[`WPM_SLEEP_BIT]       = sleep_r;
    pc_word[`WPM_AUTO_WAKE_BIT]   = auto_wake_r;
    pc_word[`WPM_LED_OUTPUTS_DISABLE_BIT]     = led_outputs_disable_r;
    pc_word[`WPM_TSYNC_DIS_BIT]   = dis_r[2];
    pc_word[`WPM_TSU_DIS_BIT]     = dis_r[3];
    pc_word[`WPM_MAC_DIS_BIT]     = dis_r[0];
    pc_word[`WPM_MAC_SYS_DIS_BIT] = dis_r[1];
    pc_word[`WPM_ENERGY_DETECT_STATUS_BIT]      = energy_detect_status_r;
    pc_word[`WPM_ENERGY_DETECT_ENABLE_BIT]       = energy_detect_enable_r;
    pc_word[`WPM_MACW_EN_BIT]     = macw_en_r;
    pc_word[`WPM_MACW_STS_BIT]    = macw_sts_r;
    pc_word[`WPM_READY_BIT]       = READY_O;
    rd_nxt = 32'h0;
    case (AHB_I.haddr[11:0])
      `WPM_PWR_CTRL_ADDR: rd_nxt = pc_word;
      `WPM_IRQ_STS_ADDR:  rd_nxt[`WPM_PE_IRQ_BIT] = pe_irq_r;
      `WPM_IRQ_EN_ADDR: begin
        rd_nxt[`WPM_PE_IRQ_BIT]    = pe_irq_en_r;
        rd_nxt[`WPM_OTHER_IRQ_BIT] = other_en_r;
      end
      `WPM_HARDWARE_CONFIG_REGISTER_ADDR:   rd_nxt[`WPM_HW_READY_BIT] = READY_O;
      `WPM_WAKE_CFG_ADDR: rd_nxt[7:0] = wcfg_r;
      default:            rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      dp_wr_r     <= 1'b0;
      dp_rd_r     <= 1'b0;
      dp_addr_r   <= 12'h0;
      HRDATA_O    <= 32'h0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      dp_wr_r   <= req_ok && AHB_I.hwrite;
      dp_rd_r   <= req_ok && !AHB_I.hwrite;
      dp_addr_r <= AHB_I.haddr[11:0];
      if (req_ok && !AHB_I.hwrite) HRDATA_O <= rd_nxt;
    end
  end

  // ready and sleep indication
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      READY_O    <= 1'b0;
      SLEEPING_O <= 1'b0;
    end else begin
      READY_O    <= (ps_r == PS_D0) && !sleep_wr;
      SLEEPING_O <= (ps_r != PS_D0);
    end
  end
endmodule : wpm_core

// >>> tb/wpm_core_asserts.sv
`timescale 1ns/1ns
`include "wpm_cfg.svh"
module wpm_core_asserts (
  input  wire logic                   CLOCK_I,
  input  wire logic                   RST_I,
  input  wire logic                   READY_O,
  input  wire logic                   SLEEPING_O,
  input  wire wpm_pkg::wpm_clk_ctrl_t CLK_CTRL_O
);
  import wpm_pkg::*;
  localparam int WAKE_MAX = `WPM_WAKE_MAX_CYC;
  int wait_cnt_r;

  // cycles awake but not ready; the pll lock phase reads as sleeping, so it is not counted
  always_ff @(posedge CLOCK_I) begin
    if (RST_I || READY_O || SLEEPING_O) begin
      wait_cnt_r <= 0;
    end else begin
      wait_cnt_r <= wait_cnt_r + 1;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  reset_to_d0_a: assert property ($fell(RST_I) |-> !SLEEPING_O && CLK_CTRL_O == 8'hff)
    else $error("reset did not land in normal state");
  sleep_not_ready_a: assert property (SLEEPING_O |-> !READY_O)
    else $error("ready high while asleep");
  sleep_sys_off_a: assert property (SLEEPING_O && $past(SLEEPING_O, 2) |-> !CLK_CTRL_O.sys_clk_en)
    else $error("system clock running while asleep");
  xtal_off_all_a: assert property (!CLK_CTRL_O.xtal_en |-> !CLK_CTRL_O.pll_en && !CLK_CTRL_O.net_clk_en)
    else $error("pll or network clock alive without crystal");
  pll_off_sys_a: assert property (!CLK_CTRL_O.pll_en |-> !CLK_CTRL_O.sys_clk_en)
    else $error("system clock alive without pll");
  ready_rise_a: assert property ($rose(READY_O) |-> !SLEEPING_O && CLK_CTRL_O.pll_en)
    else $error("ready rose outside normal state");
  ready_clocks_a: assert property (READY_O |-> CLK_CTRL_O.sys_clk_en && CLK_CTRL_O.xtal_en)
    else $error("ready while clocks are stopped");
  mac_net_a: assert property (READY_O && !CLK_CTRL_O.mac_net_clk_en |-> !CLK_CTRL_O.mac_sys_clk_en)
    else $error("mac system clock kept while net clock gated");
  wake_time_a: assert property (wait_cnt_r <= WAKE_MAX)
    else $error("wake-up took too long");
endmodule : wpm_core_asserts

// >>> tb/wpm_host.sv
`timescale 1ns/1ns
`include "wpm_cfg.svh"
module wpm_host (
  input  wire logic             clk_i,
  input  wire logic             hready_i,
  input  wire logic [31:0]      hrdata_i,
  output wpm_pkg::wpm_ahb_req_t ahb_o
);
  import wpm_pkg::*;
  logic        sel_r   = 1'b0;
  logic [31:0] addr_r  = 32'h0;
  wpm_htrans_t trans_r = WPM_HTRANS_IDLE;
  logic        wr_r    = 1'b0;
  logic [31:0] wdata_r = 32'h0;

  // fields in struct order; always one whole word
  assign ahb_o = {sel_r, addr_r, trans_r, wr_r, 3'h2, wdata_r, hready_i};

  // single transfer, each phase held until hready is seen
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    sel_r <= 1'b1;
    addr_r <= {20'h0, a};
    trans_r <= WPM_HTRANS_NONSEQ;
    wr_r <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    trans_r <= WPM_HTRANS_IDLE;
    wdata_r <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    wdata_r <= ~d; // stale data must not look valid
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // mode first, sleep enable only in a later write
  task go_sleep(input logic [31:0] cfg);
    wr(`WPM_PWR_CTRL_ADDR, cfg & 32'hefff_ffff);
    wr(`WPM_PWR_CTRL_ADDR, cfg | 32'h1000_0000);
  endtask : go_sleep

  // bounded poll of the ready flag after a wake
  task poll_ready(output logic ok);
    logic [31:0] v;
    ok = 1'b0;
    for (int i = 0; i < 2000 && !ok; i++) begin
      rd(`WPM_PWR_CTRL_ADDR, v);
      ok = v[`WPM_READY_BIT];
    end
  endtask : poll_ready
endmodule : wpm_host

// >>> tb/testbench.sv
`timescale 1ns/1ns
`include "wpm_cfg.svh"
module testbench;
  import wpm_pkg::*;
  typedef struct packed {
    logic [31:0] wd;
    logic [7:0]  mask;
    logic [7:0]  want;
    logic        slp;
  } wpm_row_t;
  localparam logic [11:0] PWR  = `WPM_PWR_CTRL_ADDR;
  localparam logic [11:0] IRQS = `WPM_IRQ_STS_ADDR;
  localparam logic [11:0] IREN = `WPM_IRQ_EN_ADDR;
  localparam logic [11:0] WCFG = `WPM_WAKE_CFG_ADDR;
  localparam logic [31:0] PE   = 32'h0002_0000;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          mac_wake = 1'b0;
  logic          energy_on = 1'b0;
  logic          host_wake = 1'b0;
  logic          other_irq = 1'b0;
  logic          phy_down = 1'b1;
  logic [2:0]    led = 3'b101;
  logic [2:0]    led_od = 3'b001;
  logic [2:0]    led_pol = 3'b011;
  logic [2:0]    led_o, led_oe;
  logic [31:0]   hrdata, rd_v;
  logic          hreadyout, hresp, irq, pin, pin_oe, ready, sleeping, ok;
  wpm_ahb_req_t  ahb;
  wpm_clk_ctrl_t clk_ctrl;
  int            num_errors = 0;
  int            n_tests = 0;
  int            cyc = 0;
  int            k;
  // disable bits first (mask, gated value), then the sleep modes D1 D2 D3
  wpm_row_t      rows [7] = '{
    '{32'h0008_0000, 8'h60, 8'h00, 1'b0}, '{32'h0004_0000, 8'h60, 8'h20, 1'b0},
    '{32'h0200_0000, 8'h10, 8'h00, 1'b0}, '{32'h0040_0000, 8'h08, 8'h00, 1'b0},
    '{32'h2000_0000, 8'h87, 8'h07, 1'b1}, '{32'h4000_0000, 8'h86, 8'h02, 1'b1},
    '{32'h6000_0000, 8'h87, 8'h00, 1'b1}};

  always #20 clk = ~clk;

  // hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  wpm_host host (.clk_i(clk), .hready_i(hreadyout), .hrdata_i(hrdata), .ahb_o(ahb));

  // short pulse and lock counts keep the run brief
  wpm_core #(.PULSE_CYC(20), .PLL_LOCK_CYC(4), .LED_N(3)) dut (
    .CLOCK_I(clk), .RST_I(rst), .AHB_I(ahb), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout),
    .HRESP_O(hresp), .MAC_WAKE_I(mac_wake), .ENERGY_ON_I(energy_on), .OTHER_IRQ_I(other_irq),
    .PHY_DOWN_I(phy_down), .HOST_WAKE_I(host_wake), .LED_I(led), .LED_OD_I(led_od),
    .LED_POL_I(led_pol), .LED_O(led_o), .LED_OE_O(led_oe), .IRQ_O(irq), .WAKE_PIN_O(pin),
    .WAKE_PIN_OE_O(pin_oe), .CLK_CTRL_O(clk_ctrl), .READY_O(ready), .SLEEPING_O(sleeping));

  task chk(input logic [31:0] got, input logic [31:0] want);
    n_tests = n_tests + 1;
    if (got !== want) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  task rdc(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] want);
    host.rd(a, rd_v);
    chk(rd_v & mask, want);
  endtask : rdc

  // registered outputs behind synchronisers need a few edges
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  task pulse(input logic [2:0] sel);
    @(posedge clk);
    {host_wake, energy_on, mac_wake} <= sel;
    repeat (3) @(posedge clk);
    {host_wake, energy_on, mac_wake} <= 3'b000;
  endtask : pulse

  task end_of_test;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({ready, sleeping, irq, pin_oe, clk_ctrl}, 12'h9ff);
    chk({hresp, hreadyout}, 2'b01);
    rdc(PWR, 32'hffff_ffff, 32'h1);
    rdc(12'h100, 32'hffff_ffff, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].slp) begin
        host.go_sleep(rows[i].wd);
        settle();
        chk({ready, sleeping}, 2'b01);
        chk(clk_ctrl & rows[i].mask, rows[i].want);
        rdc(`WPM_HARDWARE_CONFIG_REGISTER_ADDR, 32'h0800_0000, 32'h0);
        pulse(3'b100);
        host.poll_ready(ok);
        chk(ok, 1'b1);
        rdc(PWR, 32'hf000_0001, 32'h1);
        rdc(`WPM_HARDWARE_CONFIG_REGISTER_ADDR, 32'h0800_0000, 32'h0800_0000);
      end else begin
        host.wr(PWR, rows[i].wd);
        host.wr(PWR, 32'h0);
        host.wr(PWR, rows[i].wd);
        settle();
        chk(clk_ctrl & rows[i].mask, rows[i].mask);
        host.wr(PWR, rows[i].wd);
        settle();
        chk(clk_ctrl & rows[i].mask, rows[i].want);
        rdc(PWR, rows[i].wd, rows[i].wd);
        host.wr(PWR, 32'h0);
        settle();
        chk(clk_ctrl, 8'hff);
      end
    end
    // D2 with the phy awake keeps the pll running
    phy_down <= 1'b0;
    host.go_sleep(32'h4000_0000);
    settle();
    chk(clk_ctrl & 8'h86, 8'h06);
    pulse(3'b100);
    host.poll_ready(ok);
    chk(ok, 1'b1);
    phy_down <= 1'b1;
    // mode change together with sleep enable is dropped
    host.wr(PWR, 32'h3000_0000);
    settle();
    chk(sleeping, 1'b0);
    rdc(PWR, 32'hf000_0000, 32'h0);
    // a reserved mode code never leaves D0
    host.go_sleep(32'h8000_0000);
    settle();
    chk({ready, sleeping}, 2'b10);
    host.wr(PWR, 32'h0400_0000);
    settle();
    chk(led_oe, 3'(~led_od));
    chk(3'(led_o & ~led_od), 3'(~led_pol & ~led_od));
    pulse(3'b001);
    settle();
    rdc(PWR, 32'h20, 32'h20);
    rdc(IRQS, PE, 32'h0);
    host.wr(PWR, 32'h200);
    settle();
    rdc(IRQS, PE, PE);
    chk(irq, 1'b0);
    host.wr(IREN, PE | 32'h1);
    settle();
    chk(irq, 1'b1);
    host.wr(PWR, 32'h20);
    host.wr(IRQS, PE);
    host.wr(WCFG, 32'h6);
    other_irq <= 1'b1;
    settle();
    chk({irq, pin}, 2'b10);
    @(posedge clk);
    other_irq <= 1'b0;
    host.wr(WCFG, 32'he);
    host.wr(PWR, 32'h4000);
    @(posedge clk);
    energy_on <= 1'b1;
    k = 0;
    for (int c = 0; c < 60; c++) begin
      @(posedge clk);
      if (c == 2) energy_on <= 1'b0;
      #1;
      if (pin === 1'b1) k = k + 1;
    end
    chk(k, 20);
    host.wr(WCFG, 32'h42);
    settle();
    chk({pin_oe, pin}, 2'b10);
    host.wr(PWR, 32'h1_0000);
    host.wr(IRQS, PE);
    settle();
    chk(pin_oe, 1'b0);
    host.wr(WCFG, 32'h0);
    settle();
    chk({pin_oe, pin}, 2'b11);
    host.go_sleep(32'h2800_0200);
    pulse(3'b001);
    host.poll_ready(ok);
    chk(ok, 1'b1);
    host.wr(PWR, 32'h20);
    host.wr(IRQS, PE);
    host.go_sleep(32'h6800_0200);
    pulse(3'b001);
    repeat (100) @(posedge clk);
    #1;
    chk(sleeping, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk({ready, sleeping}, 2'b10);
    end_of_test();
  end
endmodule : testbench

bind wpm_core wpm_core_asserts u_asserts (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .READY_O(READY_O),
  .SLEEPING_O(SLEEPING_O), .CLK_CTRL_O(CLK_CTRL_O));
